// >>> src/sprl_pkg.sv
// Package for the serial PROM register loader: timing, map offsets, types
package sprl_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 5;           // Device clock period
   localparam int SCL_PERIOD_NS = 10000;       // Two-wire clock near 100 kHz
   localparam int QTR_CYCLES = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;  // Quarter-bit ticks
   localparam logic [9:0] QTR_LAST = 10'(QTR_CYCLES - 1);

   // ****************************************************************
   // Link constants
   // ****************************************************************
   localparam logic [6:0] PROM_SLAVE_ADDR = 7'h50;   // 1010 000b
   localparam logic [7:0] BLK0_START = 8'h00;        // First block indicator offset
   localparam logic [7:0] BLK0_FUNC = 8'h00;         // Socket function indicator
   localparam logic [7:0] BLK0_COUNT = 8'h20;        // Socket block byte count
   localparam logic [7:0] BLK0_LAST = 8'h21;         // Last socket block byte
   localparam logic [7:0] BLK1_START = 8'h4F;        // Smart card block indicator offset
   localparam logic [7:0] BLK1_FUNC = 8'h05;         // Smart card function indicator
   localparam logic [7:0] BLK1_COUNT = 8'h0E;        // Smart card block byte count
   localparam logic [7:0] BLK1_END = 8'h5F;          // End-of-list offset
   localparam logic [7:0] END_OF_LIST = 8'h80;       // End-of-list value

   // ****************************************************************
   // Image offsets
   // ****************************************************************
   localparam logic [7:0] OFS_BASE0 = 8'h08;
   localparam logic [7:0] OFS_BASE1 = 8'h09;
   localparam logic [7:0] OFS_BASE2 = 8'h0A;
   localparam logic [7:0] OFS_BASE3 = 8'h0B;
   localparam logic [7:0] OFS_IDREV = 8'h1D;
   localparam logic [7:0] OFS_GCTL0 = 8'h1E;
   localparam logic [7:0] OFS_GCTL1 = 8'h1F;
   localparam logic [7:0] OFS_GPEEN = 8'h20;
   localparam logic [7:0] OFS_GPOUT = 8'h21;
   localparam logic [7:0] OFS_CLASS0 = 8'h51;
   localparam logic [7:0] OFS_SVID0 = 8'h54;
   localparam logic [7:0] OFS_SSID0 = 8'h56;
   localparam logic [7:0] OFS_SCGCTL = 8'h58;
   localparam logic [7:0] OFS_CFG1B0 = 8'h59;
   localparam logic [7:0] OFS_CFG2B0 = 8'h5D;

   // ****************************************************************
   // Bit masks and reset defaults
   // ****************************************************************
   localparam logic [7:0] MASK_BASE0 = 8'hFE;    // Bits 7..1
   localparam logic [7:0] MASK_HI_NO5 = 8'hDF;   // Bits 7, 6, 4..0
   localparam logic [7:0] MASK_GPOUT = 8'h1F;    // Bits 4..0
   localparam logic [7:0] MASK_SCGCTL = 8'h7F;   // Bits 6..0
   localparam logic [31:0] RST_BASE = 32'h0000_0001;  // Bit 0 fixed as I/O indicator
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [23:0] RST_CLASS = 24'h00_0000;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [31:0] RST_DWORD = 32'h0000_0000;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic [31:0] legacy_base;     // Legacy socket register base
      logic [7:0] id_rev;           // Identification and revision
      logic [7:0] gen_ctl0;         // General control byte 0
      logic [7:0] gen_ctl1;         // General control byte 1
      logic [7:0] gpe_enable;       // Event enable
      logic [7:0] gp_output;        // Output register
   } sprl_sock_t;

   typedef struct packed {
      logic [23:0] class_code;
      logic [15:0] sub_vendor;
      logic [15:0] sub_id;
      logic [7:0] gen_ctl;
      logic [31:0] cfg1;
      logic [15:0] cfg2;
   } sprl_card_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_START = 4'h1,
      ST_SEND = 4'h3,
      ST_SACK = 4'h2,
      ST_RECV = 4'h6,
      ST_MACK = 4'h7,
      ST_STOP = 4'h5,
      ST_DONE = 4'h4
   } sprl_state_t;

endpackage

// >>> src/sprl_loader.sv
// Serial PROM register loader: two-wire master filling register defaults
//
// Operation
// - Fetch defaults on a rising LOAD_REQ, when PROM_PRESENT is set
// - Address the PROM at slave 1010000b
// - First block: indicator 00h, count 20h
// - Bytes 08h-0Bh fill base, byte0 bits 7-1
// - Byte 1Dh fills identification and revision
// - 1Eh fills control 0; 1Fh skips bit5
// - Byte 20h fills event enable, bit5 kept
// - Byte 21h fills output bits 4-0 only
// - Second block 05h, 0Eh, ends with 80h
// - Bytes 51h-53h fill class code
// - Bytes 54h-57h fill subsystem IDs, low first
// - Byte 58h fills control bits 6-0
// - Bytes 59h-5Ch fill configuration word 1
// - Bytes 5Dh-5Eh fill configuration word 2
// - Bytes 09h, 0Ah fill base bytes unmasked
`timescale 1ns/10ps
module sprl_loader #(parameter logic [9:0] QTR_LAST = sprl_pkg::QTR_LAST)
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST_B,
   // Start request and presence strap
   input wire logic LOAD_REQ,
   input wire logic PROM_PRESENT,
   // Two-wire pins, enables low while driving low
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE_N,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N,
   // Loaded register images
   output sprl_pkg::sprl_sock_t SOCK_REGS,
   output sprl_pkg::sprl_card_t CARD_REGS,
   // Status
   output logic LOAD_BUSY,
   output logic LOAD_DONE,
   output logic LOAD_ERR
);

   // ****************************************************************
   // Reset release and pin synchronisers
   // ****************************************************************
   logic [1:0] rst_sync_q;    // Reset release chain
   logic rst_n;               // Released reset
   logic [1:0] sda_sync_q;    // Data pin synchroniser
   logic [1:0] scl_sync_q;    // Clock pin synchroniser
   logic [1:0] req_sync_q;    // Request synchroniser
   logic [1:0] pres_sync_q;   // Presence synchroniser
   logic req_prev_q;          // Request edge memory

   // Asynchronous assert, two-flop release
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // Pins come from outside the clock domain
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sda_sync_q <= 2'h3;
         scl_sync_q <= 2'h3;
         req_sync_q <= 2'h0;
         pres_sync_q <= 2'h0;
         req_prev_q <= 1'b0;
      end
      else
      begin
         sda_sync_q <= {sda_sync_q[0], SDA_I};
         scl_sync_q <= {scl_sync_q[0], SCL_I};
         req_sync_q <= {req_sync_q[0], LOAD_REQ};
         pres_sync_q <= {pres_sync_q[0], PROM_PRESENT};
         req_prev_q <= req_sync_q[1];
      end
   end

   // ****************************************************************
   // Quarter-bit tick divider
   // ****************************************************************
   logic [9:0] div_q, div_d;  // Divider count
   logic tick;                // One-cycle quarter-bit enable

   always_comb
   begin
      tick = (div_q == QTR_LAST);
      div_d = tick ? 10'h000 : div_q + 10'h001;
   end

   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
         div_q <= 10'h000;
      else
         div_q <= div_d;
   end

   // ****************************************************************
   // Two-wire sequencer
   // ****************************************************************
   // One random read of the whole image: start, address write, offset,
   // repeated start, address read, then a streaming sequential read.
   // The stream is read byte by byte; a rising LOAD_REQ requests it.
   sprl_pkg::sprl_state_t st_q, st_d;
   logic [1:0] ph_q, ph_d;      // Quarter phase within a bit
   logic [3:0] bit_q, bit_d;    // Bit index, 8 is the ack slot
   logic [7:0] sh_q, sh_d;      // Shift register
   logic [1:0] hdr_q, hdr_d;    // Header byte being sent: 0 wr, 1 ofs, 2 rd
   logic [7:0] ofs_q, ofs_d;    // PROM offset of byte being read
   logic scl_q, scl_d;          // Drive clock low when 0
   logic sda_q, sda_d;          // Drive data low when 0
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic err_q, err_d;
   logic blk0_ok_q, blk0_ok_d;  // First block header valid
   logic blk1_ok_q, blk1_ok_d;  // Second block header valid
   logic byte_ok;               // Pulse: a data byte just arrived
   logic last_byte;             // Final offset of the image

   always_comb
   begin
      st_d = st_q;
      ph_d = ph_q;
      bit_d = bit_q;
      sh_d = sh_q;
      hdr_d = hdr_q;
      ofs_d = ofs_q;
      scl_d = scl_q;
      sda_d = sda_q;
      busy_d = busy_q;
      done_d = done_q;
      err_d = err_q;
      byte_ok = 1'b0;
      last_byte = (ofs_q == sprl_pkg::BLK1_END);
      if (st_q == sprl_pkg::ST_IDLE)
      begin
         // Rising request with PROM detected starts a load
         if (req_sync_q[1] && !req_prev_q && pres_sync_q[1])
         begin
            st_d = sprl_pkg::ST_START;
            ph_d = 2'h0;
            hdr_d = 2'h0;
            ofs_d = sprl_pkg::BLK0_START;
            busy_d = 1'b1;
            done_d = 1'b0;
            err_d = 1'b0;
         end
      end
      else if (tick)
      begin
         ph_d = ph_q + 2'h1;
         unique case (st_q)
            sprl_pkg::ST_START:
            begin
               // Phases: release both, hold, data low, clock low
               unique case (ph_q)
                  2'h0: begin scl_d = 1'b1; sda_d = 1'b1; end
                  2'h1: ;
                  2'h2: sda_d = 1'b0;
                  default:
                  begin
                     scl_d = 1'b0;
                     st_d = sprl_pkg::ST_SEND;
                     bit_d = 4'h0;
                     // Write address, then offset, then read address
                     sh_d = (hdr_q == 2'h2) ? {sprl_pkg::PROM_SLAVE_ADDR, 1'b1}
                                           : {sprl_pkg::PROM_SLAVE_ADDR, 1'b0};
                  end
               endcase
            end
            sprl_pkg::ST_SEND, sprl_pkg::ST_RECV:
            begin
               unique case (ph_q)
                  2'h0: sda_d = (st_q == sprl_pkg::ST_SEND) ? sh_q[7] : 1'b1;
                  2'h1: scl_d = 1'b1;
                  2'h2:
                  begin
                     // Clock stretching: wait while slave holds clock low
                     if (!scl_sync_q[1])
                        ph_d = ph_q;
                     else if (st_q == sprl_pkg::ST_RECV)
                        sh_d = {sh_q[6:0], sda_sync_q[1]};
                     else
                        sh_d = {sh_q[6:0], 1'b0};
                  end
                  default:
                  begin
                     scl_d = 1'b0;
                     bit_d = bit_q + 4'h1;
                     if (bit_q == 4'h7)
                        st_d = (st_q == sprl_pkg::ST_SEND) ? sprl_pkg::ST_SACK
                                                          : sprl_pkg::ST_MACK;
                  end
               endcase
            end
            sprl_pkg::ST_SACK:
            begin
               unique case (ph_q)
                  2'h0: sda_d = 1'b1;
                  2'h1: scl_d = 1'b1;
                  2'h2:
                  begin
                     if (!scl_sync_q[1])
                        ph_d = ph_q;
                     else if (sda_sync_q[1])
                        err_d = 1'b1;   // No acknowledge from the PROM
                  end
                  default:
                  begin
                     scl_d = 1'b0;
                     bit_d = 4'h0;
                     if (err_q)
                        st_d = sprl_pkg::ST_STOP;
                     else if (hdr_q == 2'h0)
                     begin
                        hdr_d = 2'h1;
                        sh_d = sprl_pkg::BLK0_START;
                        st_d = sprl_pkg::ST_SEND;
                     end
                     else if (hdr_q == 2'h1)
                     begin
                        hdr_d = 2'h2;
                        st_d = sprl_pkg::ST_START;   // Repeated start
                     end
                     else
                        st_d = sprl_pkg::ST_RECV;
                  end
               endcase
            end
            sprl_pkg::ST_MACK:
            begin
               unique case (ph_q)
                  2'h0:
                  begin
                     byte_ok = 1'b1;
                     // End of list ends the stream early
                     if (last_byte
                         || (sh_q == sprl_pkg::END_OF_LIST && ofs_q > sprl_pkg::BLK0_LAST))
                        sda_d = 1'b1;   // Not-acknowledge the last byte
                     else
                        sda_d = 1'b0;
                  end
                  2'h1: scl_d = 1'b1;
                  2'h2: if (!scl_sync_q[1]) ph_d = ph_q;
                  default:
                  begin
                     scl_d = 1'b0;
                     bit_d = 4'h0;
                     ofs_d = ofs_q + 8'h01;
                     st_d = sda_q ? sprl_pkg::ST_STOP : sprl_pkg::ST_RECV;
                  end
               endcase
            end
            sprl_pkg::ST_STOP:
            begin
               unique case (ph_q)
                  2'h0: sda_d = 1'b0;
                  2'h1: scl_d = 1'b1;
                  2'h2: sda_d = 1'b1;
                  default: st_d = sprl_pkg::ST_DONE;
               endcase
            end
            default:
            begin
               // Done or illegal code: release and report
               st_d = sprl_pkg::ST_IDLE;
               busy_d = 1'b0;
               done_d = 1'b1;
               scl_d = 1'b1;
               sda_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= sprl_pkg::ST_IDLE;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         hdr_q <= 2'h0;
         ofs_q <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         hdr_q <= hdr_d;
         ofs_q <= ofs_d;
         scl_q <= scl_d;
         sda_q <= sda_d;
         busy_q <= busy_d;
         done_q <= done_d;
         err_q <= err_d;
      end
   end

   // ****************************************************************
   // Register image loading
   // ****************************************************************
   // Only named bits change; every other bit holds its reset default.
   sprl_pkg::sprl_sock_t sock_q, sock_d;
   sprl_pkg::sprl_card_t card_q, card_d;
   logic [7:0] rb;   // Byte just received

   always_comb
   begin
      sock_d = sock_q;
      card_d = card_q;
      blk0_ok_d = blk0_ok_q;
      blk1_ok_d = blk1_ok_q;
      rb = sh_q;
      if (byte_ok)
      begin
         // Header checks decide whether a block is applied
         if (ofs_q == sprl_pkg::BLK0_START)
            blk0_ok_d = (rb == sprl_pkg::BLK0_FUNC);
         else if (ofs_q == sprl_pkg::BLK0_START + 8'h01)
            blk0_ok_d = blk0_ok_q && (rb == sprl_pkg::BLK0_COUNT);
         else if (ofs_q == sprl_pkg::BLK1_START)
            blk1_ok_d = (rb == sprl_pkg::BLK1_FUNC);
         else if (ofs_q == sprl_pkg::BLK1_START + 8'h01)
            blk1_ok_d = blk1_ok_q && (rb == sprl_pkg::BLK1_COUNT);
         if (blk0_ok_q)
         begin
            unique case (ofs_q)
               sprl_pkg::OFS_BASE0: sock_d.legacy_base[7:0] = (rb & sprl_pkg::MASK_BASE0)
                  | (sock_q.legacy_base[7:0] & ~sprl_pkg::MASK_BASE0);
               sprl_pkg::OFS_BASE1: sock_d.legacy_base[15:8] = rb;
               sprl_pkg::OFS_BASE2: sock_d.legacy_base[23:16] = rb;
               sprl_pkg::OFS_BASE3: sock_d.legacy_base[31:24] = rb;
               sprl_pkg::OFS_IDREV: sock_d.id_rev = rb;
               sprl_pkg::OFS_GCTL0: sock_d.gen_ctl0 = rb;
               sprl_pkg::OFS_GCTL1: sock_d.gen_ctl1 = (rb & sprl_pkg::MASK_HI_NO5)
                  | (sock_q.gen_ctl1 & ~sprl_pkg::MASK_HI_NO5);
               sprl_pkg::OFS_GPEEN: sock_d.gpe_enable = (rb & sprl_pkg::MASK_HI_NO5)
                  | (sock_q.gpe_enable & ~sprl_pkg::MASK_HI_NO5);
               sprl_pkg::OFS_GPOUT: sock_d.gp_output = (rb & sprl_pkg::MASK_GPOUT)
                  | (sock_q.gp_output & ~sprl_pkg::MASK_GPOUT);
               default: ;
            endcase
         end
         if (blk1_ok_q)
         begin
            unique case (ofs_q)
               sprl_pkg::OFS_CLASS0: card_d.class_code[7:0] = rb;
               sprl_pkg::OFS_CLASS0 + 8'h01: card_d.class_code[15:8] = rb;
               sprl_pkg::OFS_CLASS0 + 8'h02: card_d.class_code[23:16] = rb;
               sprl_pkg::OFS_SVID0: card_d.sub_vendor[7:0] = rb;
               sprl_pkg::OFS_SVID0 + 8'h01: card_d.sub_vendor[15:8] = rb;
               sprl_pkg::OFS_SSID0: card_d.sub_id[7:0] = rb;
               sprl_pkg::OFS_SSID0 + 8'h01: card_d.sub_id[15:8] = rb;
               sprl_pkg::OFS_SCGCTL: card_d.gen_ctl = (rb & sprl_pkg::MASK_SCGCTL)
                  | (card_q.gen_ctl & ~sprl_pkg::MASK_SCGCTL);
               sprl_pkg::OFS_CFG1B0: card_d.cfg1[7:0] = rb;
               sprl_pkg::OFS_CFG1B0 + 8'h01: card_d.cfg1[15:8] = rb;
               sprl_pkg::OFS_CFG1B0 + 8'h02: card_d.cfg1[23:16] = rb;
               sprl_pkg::OFS_CFG1B0 + 8'h03: card_d.cfg1[31:24] = rb;
               sprl_pkg::OFS_CFG2B0: card_d.cfg2[7:0] = rb;
               sprl_pkg::OFS_CFG2B0 + 8'h01: card_d.cfg2[15:8] = rb;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sock_q <= {sprl_pkg::RST_BASE, sprl_pkg::RST_BYTE, sprl_pkg::RST_BYTE,
                    sprl_pkg::RST_BYTE, sprl_pkg::RST_BYTE, sprl_pkg::RST_BYTE};
         card_q <= {sprl_pkg::RST_CLASS, sprl_pkg::RST_WORD, sprl_pkg::RST_WORD,
                    sprl_pkg::RST_BYTE, sprl_pkg::RST_DWORD, sprl_pkg::RST_WORD};
         blk0_ok_q <= 1'b0;
         blk1_ok_q <= 1'b0;
      end
      else
      begin
         sock_q <= sock_d;
         card_q <= card_d;
         blk0_ok_q <= blk0_ok_d;
         blk1_ok_q <= blk1_ok_d;
      end
   end

   // ****************************************************************
   // Outputs, from flip-flops except constant-low SCL_O and SDA_O
   // ****************************************************************
   assign SCL_O = 1'b0;
   assign SCL_OE_N = scl_q;
   assign SDA_O = 1'b0;
   assign SDA_OE_N = sda_q;
   assign SOCK_REGS = sock_q;
   assign CARD_REGS = card_q;
   assign LOAD_BUSY = busy_q;
   assign LOAD_DONE = done_q;
   assign LOAD_ERR = err_q;

endmodule // sprl_loader

// >>> tb/sprl_loader_props.sv
// Port checker for the serial PROM register loader
`timescale 1ns/10ps
module sprl_loader_props
(
   // Clock, reset, requests
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic LOAD_REQ,
   input wire logic PROM_PRESENT,
   // Pins, images, status
   input wire logic SCL_OE_N,
   input wire logic SDA_OE_N,
   input sprl_pkg::sprl_sock_t SOCK_REGS,
   input sprl_pkg::sprl_card_t CARD_REGS,
   input wire logic LOAD_BUSY
);
   // *****
   // Properties
   // *****
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);
   // Load cycles before data falls under a released clock
   logic [11:0] wait_q;
   always_ff @(posedge MCLK)
      wait_q <= !LOAD_BUSY ? 12'h001 : (SCL_OE_N && $fell(SDA_OE_N)) ? 12'h000
         : wait_q + 12'(|wait_q);
   property p_take;
      $rose(LOAD_REQ) && PROM_PRESENT && !LOAD_BUSY |-> ##[1:8] LOAD_BUSY;
   endproperty
   a_take: assert property (p_take) else $error("load not taken");
   property p_refuse;
      $rose(LOAD_REQ) && !PROM_PRESENT && !LOAD_BUSY |-> ##1 !LOAD_BUSY [*8];
   endproperty
   a_refuse: assert property (p_refuse) else $error("load without PROM");
   property p_start;
      wait_q < 12'hBB8;
   endproperty
   a_start: assert property (p_start) else $error("no start condition");
   property p_hold;
      !LOAD_BUSY |=> $stable(SOCK_REGS) && $stable(CARD_REGS);
   endproperty
   a_hold: assert property (p_hold) else $error("images moved while idle");
   property p_bit0;
      SOCK_REGS.legacy_base[0];
   endproperty
   a_bit0: assert property (p_bit0) else $error("base bit 0 changed");
   property p_ctl1;
      !SOCK_REGS.gen_ctl1[5];
   endproperty
   a_ctl1: assert property (p_ctl1) else $error("control 1 bit 5 changed");
   property p_gpe;
      !SOCK_REGS.gpe_enable[5];
   endproperty
   a_gpe: assert property (p_gpe) else $error("event enable bit 5 changed");
   property p_scc;
      !CARD_REGS.gen_ctl[7] && SOCK_REGS.gp_output[7:5] == 3'h0;
   endproperty
   a_scc: assert property (p_scc) else $error("unloaded bits changed");
endmodule // sprl_loader_props
bind sprl_loader sprl_loader_props chk_u (.MCLK(MCLK), .RST_B(RST_B), .LOAD_REQ(LOAD_REQ),
   .PROM_PRESENT(PROM_PRESENT), .SCL_OE_N(SCL_OE_N), .SDA_OE_N(SDA_OE_N),
   .SOCK_REGS(SOCK_REGS), .CARD_REGS(CARD_REGS), .LOAD_BUSY(LOAD_BUSY));

// >>> tb/sprl_prom_model.sv
// Behavioural two-wire PROM that streams the register image
`timescale 1ns/10ps
module sprl_prom_model
(
   // Lines, pulled up outside
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe_n,
   // Answer the slave address when high
   input wire logic ack_en
);
   logic [7:0] mem [0:255];  // Image, filled by the bench
   logic [7:0] sh = 8'h00;  // Receive shifter
   logic [7:0] ptr = 8'h00;  // Read offset, kept across frames
   logic adr_ph = 1'b0;  // Next byte is a slave address
   logic rd_pend = 1'b0;  // Read asked, data follows the ack
   logic rd_act = 1'b0;  // Sending data
   logic skip = 1'b0;  // The clock fall closing a start is no bit
   logic m_nack = 1'b1;  // Master answer to the last byte
   int bc = 0;  // Bit slot, 8 is the ack slot
   initial sda_oe_n = 1'b1;
   // *****
   // Frame and bit engine
   // *****
   always @(negedge sda)
      if (scl === 1'b1)
      begin
         bc = 0;
         adr_ph = 1'b1;
         rd_act = 1'b0;
         skip = 1'b1;
      end
   // Sample on the rising clock
   always @(posedge scl)
      if (bc < 8)
         sh = {sh[6:0], sda};
      else
         m_nack = sda;
   // Change data only while the clock is low
   always @(negedge scl)
      if (skip)
         skip = 1'b0;
      else if (bc == 7)
      begin
         bc = 8;
         sda_oe_n = rd_act | (adr_ph & !(ack_en && sh[7:1] == 7'h50));
         rd_pend = adr_ph & sh[0];
         if (!adr_ph && !rd_act)
            ptr = sh;
         adr_ph = 1'b0;
      end
      else
      begin
         if (bc == 8 && rd_act && !m_nack)
            ptr = ptr + 8'h01;
         if (bc == 8)
            rd_act = rd_pend | (rd_act & !m_nack);
         bc = (bc == 8) ? 0 : bc + 1;
         sda_oe_n = rd_act ? mem[ptr][7 - bc] : 1'b1;
      end
endmodule // sprl_prom_model

// >>> tb/sprl_loader_tb_top.sv
// Bench for the serial PROM register loader
`timescale 1ns/10ps
module sprl_loader_tb_top;
   // *****
   // Signals, instances, helpers
   // *****
   logic mclk, rst_b, load_req, prom_present, ack_en;  // Bench drives
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, prom_oe_n;  // Pin drivers
   logic load_busy, load_done, load_err;  // Status
   wire scl_w = scl_oe_n ? 1'b1 : scl_o;  // Pulled up when released
   wire sda_w = (sda_oe_n ? 1'b1 : sda_o) & prom_oe_n;
   sprl_pkg::sprl_sock_t sock_regs, sock_e;
   sprl_pkg::sprl_card_t card_regs, card_e;
   int n_errors, n_tests, seed, k;
   sprl_loader #(.QTR_LAST(10'h003)) dut_u (.MCLK(mclk), .RST_B(rst_b), .LOAD_REQ(load_req),
      .PROM_PRESENT(prom_present), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n),
      .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .SOCK_REGS(sock_regs),
      .CARD_REGS(card_regs), .LOAD_BUSY(load_busy), .LOAD_DONE(load_done), .LOAD_ERR(load_err));
   sprl_prom_model prom_u (.scl(scl_w), .sda(sda_w), .sda_oe_n(prom_oe_n), .ack_en(ack_en));
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic complete_run();
      if (n_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask
   task automatic fail(input string msg);
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
         fail("status flag");
   endtask
   task automatic cmp_sock(input sprl_pkg::sprl_sock_t got, input sprl_pkg::sprl_sock_t exp);
      n_tests++;
      if (got !== exp)
         fail("socket image");
   endtask
   task automatic cmp_card(input sprl_pkg::sprl_card_t got, input sprl_pkg::sprl_card_t exp);
      n_tests++;
      if (got !== exp)
         fail("card image");
   endtask
   function automatic logic [7:0] m(input int a);
      return prom_u.mem[a];
   endfunction
   // Expected socket image; a bad header leaves it alone
   function automatic sprl_pkg::sprl_sock_t f_sock(input sprl_pkg::sprl_sock_t p);
      sprl_pkg::sprl_sock_t e;
      e = p;
      if (m(0) === 8'h00 && m(1) === 8'h20)
      begin
         e.legacy_base = {m(8'h0B), m(8'h0A), m(8'h09), m(8'h08) & 8'hFE | 8'h01};
         e.id_rev = m(8'h1D);
         e.gen_ctl0 = m(8'h1E);
         e.gen_ctl1 = m(8'h1F) & 8'hDF | p.gen_ctl1 & 8'h20;
         e.gpe_enable = m(8'h20) & 8'hDF | p.gpe_enable & 8'h20;
         e.gp_output = m(8'h21) & 8'h1F | p.gp_output & 8'hE0;
      end
      return e;
   endfunction
   function automatic sprl_pkg::sprl_card_t f_card(input sprl_pkg::sprl_card_t p);
      sprl_pkg::sprl_card_t e;
      e = p;
      if (m(8'h4F) === 8'h05 && m(8'h50) === 8'h0E)
      begin
         e.class_code = {m(8'h53), m(8'h52), m(8'h51)};
         e.sub_vendor = {m(8'h55), m(8'h54)};
         e.sub_id = {m(8'h57), m(8'h56)};
         e.gen_ctl = m(8'h58) & 8'h7F | p.gen_ctl & 8'h80;
         e.cfg1 = {m(8'h5C), m(8'h5B), m(8'h5A), m(8'h59)};
         e.cfg2 = {m(8'h5E), m(8'h5D)};
      end
      return e;
   endfunction
   // Random image; 80h avoided since it would end the stream early
   task automatic fill(input logic [7:0] cnt0);
      for (int i = 0; i < 256; i++)
      begin
         prom_u.mem[i] = 8'($random(seed));
         if (prom_u.mem[i] === 8'h80)
            prom_u.mem[i] = 8'h00;
      end
      prom_u.mem[0] = 8'h00;
      prom_u.mem[1] = cnt0;
      prom_u.mem[8'h4F] = 8'h05;
      prom_u.mem[8'h50] = 8'h0E;
      prom_u.mem[8'h5F] = 8'h80;
   endtask
   // Request low first, then high until the load ends or is ignored
   task automatic run_load(input int bound);
      repeat (4) tick();
      load_req = 1'b1;
      for (k = 0; k < bound && (k < 20 || load_busy === 1'b1); k++)
         tick();
      if (k >= bound)
      begin
         fail("load timed out");
         complete_run();
      end
      load_req = 1'b0;
   endtask
   // *****
   // Main sequence
   // *****
   initial
   begin
      rst_b = 1'b0;
      load_req = 1'b0;
      prom_present = 1'b0;
      ack_en = 1'b1;
      seed = 57;
      n_errors = 0;
      n_tests = 0;
      repeat (10) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      sock_e = {sprl_pkg::RST_BASE, 40'h0};
      card_e = 112'h0;
      tick();
      cmp_sock(sock_regs, sock_e);
      cmp_card(card_regs, card_e);
      run_load(40);
      cmp_flag(load_busy | load_done, 1'b0);
      prom_present = 1'b1;
      ack_en = 1'b0;
      run_load(900);
      cmp_flag(load_err & load_done, 1'b1);
      cmp_sock(sock_regs, sock_e);
      ack_en = 1'b1;
      fill(8'h20);
      prom_u.mem[8'h08] = 8'h00;
      prom_u.mem[8'h1F] = 8'hFF;
      prom_u.mem[8'h20] = 8'hFF;
      prom_u.mem[8'h21] = 8'hFF;
      prom_u.mem[8'h58] = 8'hFF;
      // Good image, then one whose first block count is wrong
      for (int j = 0; j < 2; j++)
      begin
         sock_e = f_sock(sock_e);
         card_e = f_card(card_e);
         run_load(20000);
         cmp_sock(sock_regs, sock_e);
         cmp_card(card_regs, card_e);
         cmp_flag(load_err | !load_done, 1'b0);
         cmp_flag(prom_u.ptr === 8'h5F, 1'b1);
         fill(8'h21);
      end
      complete_run();
   end
endmodule // sprl_loader_tb_top
